// File: tap_host.sv
// Host model: drives test clock, mode select and serial input, samples serial output.
// Assumes one caller at a time; the test clock rests high between frames.
`timescale 1ns/1ns
module tap_host
(
  input  wire logic i_core_clk,
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  // Pins rest high at time zero, as their pull-ups would leave them.
  initial
  begin
    o_tck = 1'b1;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end

  // One 48 ns period, low 8 cycles and high 4; output is taken just before the rise.
  task automatic step(input logic ms, input logic di, output logic dq);
    @(posedge i_core_clk);
    o_tck <= 1'b0;
    o_tms <= ms;
    o_tdi <= di;
    repeat (8) @(posedge i_core_clk);
    dq = i_tdo;
    o_tck <= 1'b1;
    repeat (3) @(posedge i_core_clk);
  endtask

  // Five highs reach test-logic-reset from anywhere; a low then leaves it for idle.
  task automatic to_idle();
    logic q;
    repeat (5) step(1'b1, ~o_tdi, q);
    step(1'b0, ~o_tdi, q);
  endtask

  // One scan from idle back to idle; unused serial input toggles so it never looks held.
  task automatic scan(input logic ir, input int n, input logic [9:0] din,
                      output logic [9:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~o_tdi, q);
    if (ir)
      step(1'b1, ~o_tdi, q);
    repeat (2) step(1'b0, ~o_tdi, q);
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    step(1'b1, ~o_tdi, q);
    step(1'b0, ~o_tdi, q);
  endtask
endmodule

// File: tap_pkg.sv
// Package for the test access port scan logic: TAP states, instruction codes,
// data path selections and register widths.
// Assumes nothing of its surroundings; every user names items as tap_pkg::name.
package tap_pkg;

  // Controller states, one-hot.
  typedef enum logic [15:0] {
    TAP_RESET     = 16'h0001,
    TAP_IDLE      = 16'h0002,
    TAP_SEL_DR    = 16'h0004,
    TAP_CAP_DR    = 16'h0008,
    TAP_SHIFT_DR  = 16'h0010,
    TAP_EXIT1_DR  = 16'h0020,
    TAP_PAUSE_DR  = 16'h0040,
    TAP_EXIT2_DR  = 16'h0080,
    TAP_UPD_DR    = 16'h0100,
    TAP_SEL_IR    = 16'h0200,
    TAP_CAP_IR    = 16'h0400,
    TAP_SHIFT_IR  = 16'h0800,
    TAP_EXIT1_IR  = 16'h1000,
    TAP_PAUSE_IR  = 16'h2000,
    TAP_EXIT2_IR  = 16'h4000,
    TAP_UPD_IR    = 16'h8000
  } tap_state_e;

  // Selected serial data path between serial input and output, one-hot.
  typedef enum logic [2:0] {
    TAP_PATH_BYP  = 3'h1,
    TAP_PATH_DBG  = 3'h2,
    TAP_PATH_PGM  = 3'h4
  } tap_path_e;

  localparam int unsigned IR_W      = 3;
  localparam int unsigned DBG_W     = 10;
  localparam int unsigned PGM_W     = 3;

  localparam logic [2:0] IR_EXTEST  = 3'h0;
  localparam logic [2:0] IR_SAMPLE  = 3'h1;
  localparam logic [2:0] IR_DEBUG   = 3'h2;
  localparam logic [2:0] IR_BYP0    = 3'h3;
  localparam logic [2:0] IR_PROG    = 3'h4;
  localparam logic [2:0] IR_BYP1    = 3'h5;
  localparam logic [2:0] IR_RSVD    = 3'h6;
  localparam logic [2:0] IR_BYP2    = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  localparam logic [9:0] DBG_RESET  = 10'h000;
  localparam logic [2:0] PGM_RESET  = 3'h0;

endpackage

// File: tap_scan.sv
// TAP controller with instruction and data scan registers, sampled on the core clock.
// Assumes the host keeps the test clock below a third of the core clock rate.
// Notes on behaviour
// - Test-logic-reset forces bypass instruction code.
// - Capture-IR loads 001 into shift register.
// - Shift-IR shifts input toward output serially.
// - Update-IR falling edge copies code; exits hold.
// - Codes 000, 001 keep previous data path.
// - Codes 011, 101, 111 select bypass bit.
// - Code 010 selects ten-bit debug register.
// - Code 100 selects three-bit programming register.
// - Shift-DR shifts selected register out and in.
// - Update-DR falling edge latches parallel buffer.
// - Same edge reloads shift register from the i_dbg_tx or i_pgm_tx input.
// - DR states never touch instruction registers.
// - Power-on gives reset state, bypass selected.
// - TMS high keeps controller in reset.
// - Stopped test clock freezes all state except strobe clearing and the reset-state bypass force.
// - Private instruction recognised at update-IR latch.
// - Private instruction held until replaced or reset.
`timescale 1ns/1ns
module tap_scan
(
  input  wire logic                         i_core_clk,
  input  wire logic                         i_resetn,
  input  wire logic                         i_tck,
  input  wire logic                         i_tms,
  input  wire logic                         i_tdi,
  output logic                              o_tdo,
  output logic                              o_tdo_oe,
  output logic [tap_pkg::IR_W-1:0]          o_instruction_code,
  output logic                              o_dbg_channel,
  output logic                              o_pgm_channel,
  output logic [tap_pkg::DBG_W-1:0]         o_dbg_rx,
  output logic                              o_dbg_rx_stb,
  input  wire logic [tap_pkg::DBG_W-1:0]    i_dbg_tx,
  output logic [tap_pkg::PGM_W-1:0]         o_pgm_rx,
  output logic                              o_pgm_rx_stb,
  input  wire logic [tap_pkg::PGM_W-1:0]    i_pgm_tx,
  output logic [15:0]                       o_state
);

  typedef struct packed {
    tap_pkg::tap_state_e        st;
    logic [tap_pkg::IR_W-1:0]   ir_sh;
    logic [tap_pkg::IR_W-1:0]   ir;
    tap_pkg::tap_path_e         path;
    logic                       byp;
    logic [tap_pkg::DBG_W-1:0]  dbg_sh;
    logic [tap_pkg::DBG_W-1:0]  dbg_buf;
    logic [tap_pkg::PGM_W-1:0]  pgm_sh;
    logic [tap_pkg::PGM_W-1:0]  pgm_buf;
    logic                       tdo;
    logic                       oe;
    logic                       dbg_stb;
    logic                       pgm_stb;
  } tap_scan_s;

  tap_scan_s s_q;
  tap_scan_s s_d;
  logic      tck_rise;
  logic      tck_fall;
  logic      tms_s;
  logic      tdi_s;

  // Every pin passes two flip-flops before the controller sees it.
  tap_sync u_sync
  (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_tck      (i_tck),
    .i_tms      (i_tms),
    .i_tdi      (i_tdi),
    .o_rise     (tck_rise),
    .o_fall     (tck_fall),
    .o_tms      (tms_s),
    .o_tdi      (tdi_s)
  );

  // Next controller state for a rising test clock edge, standard TAP graph.
  function automatic tap_pkg::tap_state_e next_state(input tap_pkg::tap_state_e st,
                                                     input logic tms);
    tap_pkg::tap_state_e n;
    n = tap_pkg::TAP_RESET;
    case (st)
      tap_pkg::TAP_RESET:    n = tms ? tap_pkg::TAP_RESET    : tap_pkg::TAP_IDLE;
      tap_pkg::TAP_IDLE:     n = tms ? tap_pkg::TAP_SEL_DR   : tap_pkg::TAP_IDLE;
      tap_pkg::TAP_SEL_DR:   n = tms ? tap_pkg::TAP_SEL_IR   : tap_pkg::TAP_CAP_DR;
      tap_pkg::TAP_CAP_DR:   n = tms ? tap_pkg::TAP_EXIT1_DR : tap_pkg::TAP_SHIFT_DR;
      tap_pkg::TAP_SHIFT_DR: n = tms ? tap_pkg::TAP_EXIT1_DR : tap_pkg::TAP_SHIFT_DR;
      tap_pkg::TAP_EXIT1_DR: n = tms ? tap_pkg::TAP_UPD_DR   : tap_pkg::TAP_PAUSE_DR;
      tap_pkg::TAP_PAUSE_DR: n = tms ? tap_pkg::TAP_EXIT2_DR : tap_pkg::TAP_PAUSE_DR;
      tap_pkg::TAP_EXIT2_DR: n = tms ? tap_pkg::TAP_UPD_DR   : tap_pkg::TAP_SHIFT_DR;
      tap_pkg::TAP_UPD_DR:   n = tms ? tap_pkg::TAP_SEL_DR   : tap_pkg::TAP_IDLE;
      tap_pkg::TAP_SEL_IR:   n = tms ? tap_pkg::TAP_RESET    : tap_pkg::TAP_CAP_IR;
      tap_pkg::TAP_CAP_IR:   n = tms ? tap_pkg::TAP_EXIT1_IR : tap_pkg::TAP_SHIFT_IR;
      tap_pkg::TAP_SHIFT_IR: n = tms ? tap_pkg::TAP_EXIT1_IR : tap_pkg::TAP_SHIFT_IR;
      tap_pkg::TAP_EXIT1_IR: n = tms ? tap_pkg::TAP_UPD_IR   : tap_pkg::TAP_PAUSE_IR;
      tap_pkg::TAP_PAUSE_IR: n = tms ? tap_pkg::TAP_EXIT2_IR : tap_pkg::TAP_PAUSE_IR;
      tap_pkg::TAP_EXIT2_IR: n = tms ? tap_pkg::TAP_UPD_IR   : tap_pkg::TAP_SHIFT_IR;
      tap_pkg::TAP_UPD_IR:   n = tms ? tap_pkg::TAP_SEL_DR   : tap_pkg::TAP_IDLE;
      default:               n = tap_pkg::TAP_RESET;
    endcase
    return n;
  endfunction

  // Path chosen by an instruction code; no-op and reserved codes keep the old one.
  function automatic tap_pkg::tap_path_e decode_path(input logic [2:0] code,
                                                     input tap_pkg::tap_path_e old);
    tap_pkg::tap_path_e p;
    p = old;
    case (code)
      tap_pkg::IR_DEBUG: p = tap_pkg::TAP_PATH_DBG;
      tap_pkg::IR_PROG:  p = tap_pkg::TAP_PATH_PGM;
      tap_pkg::IR_BYP0,
      tap_pkg::IR_BYP1,
      tap_pkg::IR_BYP2:  p = tap_pkg::TAP_PATH_BYP;
      default:           p = old;
    endcase
    return p;
  endfunction

  // State moves only on a found test clock edge, except strobe clearing and the reset-state bypass force, so a parked clock freezes it.
  always_comb
  begin
    s_d         = s_q;
    s_d.dbg_stb = 1'b0;
    s_d.pgm_stb = 1'b0;
    if (tck_rise)
    begin
      s_d.st = next_state(s_q.st, tms_s);
      case (s_q.st)
        tap_pkg::TAP_CAP_IR:
          s_d.ir_sh = tap_pkg::IR_CAPTURE;
        tap_pkg::TAP_SHIFT_IR:
          s_d.ir_sh = {tdi_s, s_q.ir_sh[tap_pkg::IR_W-1:1]};
        tap_pkg::TAP_SHIFT_DR:
        begin
          // Only the selected register moves; instruction registers stay put.
          case (s_q.path)
            tap_pkg::TAP_PATH_DBG:
              s_d.dbg_sh = {tdi_s, s_q.dbg_sh[tap_pkg::DBG_W-1:1]};
            tap_pkg::TAP_PATH_PGM:
              s_d.pgm_sh = {tdi_s, s_q.pgm_sh[tap_pkg::PGM_W-1:1]};
            default:
              s_d.byp = tdi_s;
          endcase
        end
        tap_pkg::TAP_CAP_DR:
          s_d.byp = 1'b0;
        default:
          s_d.ir_sh = s_q.ir_sh;
      endcase
    end
    if (tck_fall)
    begin
      // Output changes on the falling edge so the host samples it stable.
      s_d.oe  = (s_q.st == tap_pkg::TAP_SHIFT_DR) || (s_q.st == tap_pkg::TAP_SHIFT_IR);
      s_d.tdo = 1'b1;
      case (s_q.st)
        tap_pkg::TAP_SHIFT_IR:
          s_d.tdo = s_q.ir_sh[0];
        tap_pkg::TAP_SHIFT_DR:
          case (s_q.path)
            tap_pkg::TAP_PATH_DBG: s_d.tdo = s_q.dbg_sh[0];
            tap_pkg::TAP_PATH_PGM: s_d.tdo = s_q.pgm_sh[0];
            default:               s_d.tdo = s_q.byp;
          endcase
        tap_pkg::TAP_UPD_IR:
        begin
          s_d.ir   = s_q.ir_sh;
          s_d.path = decode_path(s_q.ir_sh, s_q.path);
        end
        tap_pkg::TAP_UPD_DR:
          case (s_q.path)
            tap_pkg::TAP_PATH_DBG:
            begin
              s_d.dbg_buf = s_q.dbg_sh;
              s_d.dbg_sh  = i_dbg_tx;
              s_d.dbg_stb = 1'b1;
            end
            tap_pkg::TAP_PATH_PGM:
            begin
              s_d.pgm_buf = s_q.pgm_sh;
              s_d.pgm_sh  = i_pgm_tx;
              s_d.pgm_stb = 1'b1;
            end
            default:
              s_d.byp = s_q.byp;
          endcase
        tap_pkg::TAP_RESET:
        begin
          s_d.ir   = tap_pkg::IR_BYP0;
          s_d.path = tap_pkg::TAP_PATH_BYP;
        end
        default:
          s_d.ir = s_q.ir;
      endcase
    end
    // Reset state also forces bypass at once, without waiting for an edge.
    if (s_q.st == tap_pkg::TAP_RESET)
    begin
      s_d.ir   = tap_pkg::IR_BYP0;
      s_d.path = tap_pkg::TAP_PATH_BYP;
    end
  end

  // Power-on lands in test-logic-reset with bypass loaded.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      s_q <= '{st: tap_pkg::TAP_RESET, ir_sh: tap_pkg::IR_CAPTURE,
               ir: tap_pkg::IR_BYP0, path: tap_pkg::TAP_PATH_BYP, byp: 1'b0,
               dbg_sh: tap_pkg::DBG_RESET, dbg_buf: tap_pkg::DBG_RESET,
               pgm_sh: tap_pkg::PGM_RESET, pgm_buf: tap_pkg::PGM_RESET,
               tdo: 1'b1, oe: 1'b0, dbg_stb: 1'b0, pgm_stb: 1'b0};
    else
      s_q <= s_d;
  end

  // Channels stand while a private instruction sits in the parallel register.
  assign o_tdo              = s_q.tdo;
  assign o_tdo_oe           = s_q.oe;
  assign o_instruction_code = s_q.ir;
  assign o_dbg_channel      = (s_q.ir == tap_pkg::IR_DEBUG);
  assign o_pgm_channel      = (s_q.ir == tap_pkg::IR_PROG);
  assign o_dbg_rx           = s_q.dbg_buf;
  assign o_dbg_rx_stb       = s_q.dbg_stb;
  assign o_pgm_rx           = s_q.pgm_buf;
  assign o_pgm_rx_stb       = s_q.pgm_stb;
  assign o_state            = s_q.st;

endmodule

// File: tap_scan_props.sv
// Checker for the scan logic, fed from the ports of tap_scan through the bind below.
// Assumes the test clock pin rests high whenever reset is released.
`timescale 1ns/1ns
module tap_scan_props
(
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  input wire logic        i_tck,
  input wire logic        o_tdo_oe,
  input wire logic [2:0]  o_instruction_code,
  input wire logic        o_dbg_channel,
  input wire logic        o_pgm_channel,
  input wire logic [9:0]  o_dbg_rx,
  input wire logic        o_dbg_rx_stb,
  input wire logic        o_pgm_rx_stb,
  input wire logic [15:0] o_state
);
  // One domain; the pins reach the logic about three core cycles late, hence the slack.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_RESET_CODE: assert property (
    (o_state == tap_pkg::TAP_RESET) [*2] |-> o_instruction_code == tap_pkg::IR_BYP0)
    else $error("Code is not bypass in the reset state.");
  AST_IR_HOLD_DR: assert property (
    (|o_state[8:2]) && $past(|o_state[8:2]) |-> $stable(o_instruction_code))
    else $error("Code moved during a data scan.");
  AST_DBG_CHAN: assert property (
    $stable(o_instruction_code) |-> o_dbg_channel == (o_instruction_code == 3'h2))
    else $error("Debug channel does not follow the code.");
  AST_PGM_CHAN: assert property (
    $stable(o_instruction_code) |-> o_pgm_channel == (o_instruction_code == 3'h4))
    else $error("Programming channel does not follow the code.");
  AST_DBG_PULSE: assert property (o_dbg_rx_stb |=> !o_dbg_rx_stb)
    else $error("Debug strobe longer than one cycle.");
  AST_PGM_PULSE: assert property (o_pgm_rx_stb |=> !o_pgm_rx_stb)
    else $error("Programming strobe longer than one cycle.");
  AST_DBG_RX_CAUSE: assert property (
    $changed(o_dbg_rx) |-> (o_dbg_rx_stb || $past(o_dbg_rx_stb)) or (##1 o_dbg_rx_stb))
    else $error("Debug buffer changed without a strobe.");
  AST_IDLE_QUIET: assert property (o_state == tap_pkg::TAP_IDLE |-> !o_tdo_oe)
    else $error("Serial output driven in idle.");
  AST_LEAVE_RESET: assert property (
    $past(o_state) == tap_pkg::TAP_RESET && o_state != tap_pkg::TAP_RESET |->
    o_state == tap_pkg::TAP_IDLE)
    else $error("Reset state left to a state other than idle.");
  AST_FREEZE: assert property (
    !i_tck [*8] |-> $stable(o_state) && $stable(o_instruction_code))
    else $error("State moved while the test clock was low.");
endmodule

bind tap_scan tap_scan_props tap_scan_props_i (.*);

// File: tap_sync.sv
// Two-flip-flop synchroniser plus edge finder for the test clock, mode select
// and serial input pins.
// Assumes pins are asynchronous to i_core_clk and the test clock is slower
// than a third of the core clock.
`timescale 1ns/1ns
module tap_sync
(
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic i_tck,
  input  wire logic i_tms,
  input  wire logic i_tdi,
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_tms,
  output logic      o_tdi
);

  typedef struct packed {
    logic [2:0] m1;
    logic [2:0] m2;
    logic       tck_old;
  } tap_sync_s;

  tap_sync_s s_q;
  tap_sync_s s_d;

  // The first stage feeds only the second; edges come from stage two and its copy.
  always_comb
  begin
    s_d         = s_q;
    s_d.m1      = {i_tck, i_tms, i_tdi};
    s_d.m2      = s_q.m1;
    s_d.tck_old = s_q.m2[2];
  end

  // Idle levels follow the weak pull-ups, so the clock starts high.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      s_q <= '{m1: 3'h7, m2: 3'h7, tck_old: 1'b1};
    else
      s_q <= s_d;
  end

  assign o_rise = s_q.m2[2] & ~s_q.tck_old;
  assign o_fall = ~s_q.m2[2] & s_q.tck_old;
  assign o_tms  = s_q.m2[1];
  assign o_tdi  = s_q.m2[0];

endmodule

// File: tb_tap_scan.sv
// Bench for the scan logic: the host model drives the pins, a model here predicts results.
// Assumes tap_host on the pin side and the checker bound to tap_scan.
`timescale 1ns/1ns
module tb_tap_scan;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        tck, tms, tdi, tdo, dch, pch;
  logic [2:0]  ptx = '0;
  logic [2:0]  mprx = '0;
  logic [2:0]  sr_p = tap_pkg::PGM_RESET;
  logic [2:0]  prx, code, ecode;
  logic [9:0]  dtx = '0;
  logic [9:0]  mdrx = '0;
  logic [9:0]  sr_d = tap_pkg::DBG_RESET;
  logic [9:0]  drx, dout;
  logic [15:0] st;
  logic [2:0]  seq [10] = '{3'h2, 3'h0, 3'h1, 3'h4, 3'h6, 3'h3, 3'h2, 3'h5, 3'h4, 3'h7};
  int          bad_count = 0;
  int          compares = 0;
  int          path = 0;

  // Core clock, 4 ns period.
  always #2 clk = ~clk;

  // Device and host; strobes are judged by the checker alone.
  tap_scan tap_scan_i
  (
    .i_core_clk(clk), .i_resetn(rstn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(), .o_instruction_code(code), .o_dbg_channel(dch),
    .o_pgm_channel(pch), .o_dbg_rx(drx), .o_dbg_rx_stb(), .i_dbg_tx(dtx),
    .o_pgm_rx(prx), .o_pgm_rx_stb(), .i_pgm_tx(ptx), .o_state(st)
  );
  tap_host tap_host_i
  (
    .i_core_clk(clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One data scan on the modelled path; the bypass bit reads 0 then echoes the input.
  task automatic dr_scan();
    logic [9:0] d, tx, e;
    int n;
    d = 10'($urandom);
    tx = 10'($urandom);
    n = (path == 1) ? 10 : (path == 2) ? 3 : 2;
    e = (path == 1) ? sr_d : (path == 2) ? {7'h0, sr_p} : {8'h0, d[0], 1'b0};
    dtx <= tx;
    ptx <= tx[2:0];
    tap_host_i.scan(1'b0, n, d, dout);
    for (int i = 0; i < n; i++)
      chk(dout[i], e[i]);
    if (path == 1)
      {mdrx, sr_d} = {d, tx};
    if (path == 2)
      {mprx, sr_p} = {d[2:0], tx[2:0]};
    chk(drx, mdrx);
    chk(prx, mprx);
    chk(code, ecode);
  endtask

  // Every code, ordered so that the no-operation and reserved codes follow private ones.
  initial
  begin
    void'($urandom(48144));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(st, tap_pkg::TAP_RESET);
    chk(code, tap_pkg::IR_BYP0);
    tap_host_i.to_idle();
    // The state register takes the last rise in the very step the host returns; let it settle.
    repeat (2) @(posedge clk);
    chk(st, tap_pkg::TAP_IDLE);
    foreach (seq[k])
    begin
      ecode = seq[k];
      tap_host_i.scan(1'b1, 3, {7'h0, ecode}, dout);
      chk(dout[2:0], tap_pkg::IR_CAPTURE);
      chk(code, ecode);
      chk(dch, ecode == tap_pkg::IR_DEBUG);
      chk(pch, ecode == tap_pkg::IR_PROG);
      if (ecode == tap_pkg::IR_DEBUG)
        path = 1;
      else if (ecode == tap_pkg::IR_PROG)
        path = 2;
      else if (ecode inside {3'h3, 3'h5, 3'h7})
        path = 0;
      repeat (2) dr_scan();
    end
    tap_host_i.to_idle();
    chk(code, tap_pkg::IR_BYP0);
    end_of_test();
  end

  // Watchdog well beyond the roughly 15 us that the sequence needs.
  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule
